// [src/ccop_pkg.sv]
// Constants, field codes and carrier types of the timer register block.
// Assumes one 50 MHz clock and a 16-bit internal bus that uses word indices.
// Functional notes
// - Each capcomp register is 16 bits, capture or compare by io control.
// - Capture loads the channel counter on the selected edge and sets flag.
// - Compare sets the match flag when register equals the counter.
// - Compare-match pin action follows the io control setting.
// - Capcomp registers take word accesses only.
// - Capcomp registers reset to all ones on reset and standby.
// - Channel 2 compare-matches go out to the pulse sequencer.
// - Eight 16-bit down-counters count on selected prescaled ticks.
// - Software loads counter, then sets start; counting runs while start is 1.
// - Underflow clears counter and start, stops, sets status flag together.
// - Linked channel 1 or 2 compare-match sets start when enabled.
// - Down-counters take word accesses only.
// - Down-counters reset to zero on reset and standby.
// - Offset base latches channel 1 counter on selected capture-A edge.
// - Offset base is word-read only; writes do nothing.
// - Offset base resets to zero on reset and standby.
// - Period match sets flag, restarts counter, copies staging into duty.
// - Period registers are 16-bit word RW, reset to all ones.
// - Each PWM channel has a 16-bit RW duty staging register.
// - Staging registers are word-only and reset to all ones.
// - Four 16-bit duty registers, one per PWM channel.
// - Counter equal to duty drives the PWM pin to 0.
// - Period match with non-zero duty drives pin 1, reloads counter with 1.
// - Duty at least period holds pin 1; zero duty holds pin 0.
// - Each one-shot pin is 1 while counting, 0 after underflow.
package ccop_pkg;
   // Word indices on the internal bus
   localparam logic [6:0] CC_BASE    = 7'h00;
   localparam logic [6:0] DOWN_BASE  = 7'h12;
   localparam logic [6:0] OBASE_IDX  = 7'h1A;
   localparam logic [6:0] PERIOD_BASE = 7'h1B;
   localparam logic [6:0] STAGE_BASE = 7'h1F;
   localparam logic [6:0] DUTY_BASE  = 7'h23;
   localparam logic [6:0] START_IDX  = 7'h27;
   localparam logic [6:0] LINK_IDX   = 7'h28;
   localparam logic [6:0] CCFLAG_LO  = 7'h29;
   localparam logic [6:0] CCFLAG_HI  = 7'h2A;
   localparam logic [6:0] DFLAG_IDX  = 7'h2B;
   localparam logic [6:0] PFLAG_IDX  = 7'h2C;
   // Reset values
   localparam logic [15:0] CC_RST     = 16'hFFFF;
   localparam logic [15:0] DOWN_RST   = 16'h0000;
   localparam logic [15:0] OBASE_RST  = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] STAGE_RST  = 16'hFFFF;
   localparam logic [15:0] DUTY_RST   = 16'hFFFF;
   localparam logic [15:0] PWM_CNT_RST = 16'h0001;
   localparam logic [15:0] PWM_RELOAD = 16'h0001;
   // Edge select and compare pin action codes
   localparam logic [1:0] EDGE_RISE  = 2'h0;
   localparam logic [1:0] EDGE_FALL  = 2'h1;
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_LOW    = 2'h1;
   localparam logic [1:0] ACT_HIGH   = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;

   typedef struct packed {
      logic       capture;
      logic [1:0] edge_sel;
      logic [1:0] out_act;
   } ccop_io_type;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        word;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } ccop_bus_req_type;

   typedef struct packed {
      logic        ack;
      logic [15:0] rdata;
   } ccop_bus_rsp_type;

   // Edges not named rise or fall count both ways
   function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
      if (sel == EDGE_RISE) return cur & ~prev;
      if (sel == EDGE_FALL) return ~cur & prev;
      return cur ^ prev;
   endfunction

   // Channel 1..5 counter (0..4) that serves each capcomp register
   function automatic logic [2:0] cc_chan(input int i);
      if (i < 6) return 3'h0;
      if (i < 8) return 3'h1;
      if (i < 12) return 3'h2;
      if (i < 16) return 3'h3;
      return 3'h4;
   endfunction
endpackage

// [src/ccop_oneshot.sv]
// One down-counter of the one-shot group.
// Assumes start is held by the parent and tick is a one-cycle prescaled pulse.
module ccop_oneshot (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        standby,
   // Control
   input  wire logic        wr_en,
   input  wire logic [15:0] wdata,
   input  wire logic        tick,
   input  wire logic        run,
   // Status
   output logic [15:0]      count,
   output logic             underflow
);
   typedef struct packed {
      logic [15:0] cnt;
   } ccop_os_state_type;

   ccop_os_state_type st_ff;
   ccop_os_state_type nxt_st;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   assign underflow = run & tick & ~wr_en & ~standby & (st_ff.cnt == ccop_pkg::DOWN_RST);

   always_comb begin
      nxt_st = st_ff;
      if (standby) begin
         nxt_st.cnt = ccop_pkg::DOWN_RST;
      end else if (wr_en) begin
         nxt_st.cnt = wdata;
      end else if (run && tick) begin
         nxt_st.cnt = underflow ? ccop_pkg::DOWN_RST : st_ff.cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff.cnt <= ccop_pkg::DOWN_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign count = st_ff.cnt;

   a_os_underflow: assert property (underflow |=> count == 16'h0000)
      else $error("down-counter not zero after underflow");
   a_os_decrement: assert property (run && tick && !wr_en && !standby && count != 16'h0000 |=> count == $past(count) - 16'h0001)
      else $error("down-counter missed a decrement");
endmodule // ccop_oneshot

// [src/ccop_pwm.sv]
// One buffered PWM channel: counter, period, staging and duty registers.
// Assumes tick is a one-cycle prescaled pulse from the shared prescaler.
module ccop_pwm (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        standby,
   // Tick and register writes
   input  wire logic        tick,
   input  wire logic        wr_period,
   input  wire logic        wr_stage,
   input  wire logic        wr_duty,
   input  wire logic [15:0] wdata,
   // Register, pin and period-match outputs
   output logic [15:0]      period,
   output logic [15:0]      stage,
   output logic [15:0]      duty,
   output logic             pwm_output_pin,
   output logic             period_match
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] period;
      logic [15:0] stage;
      logic [15:0] duty;
      logic        pin;
   } ccop_pwm_state_type;

   localparam ccop_pwm_state_type ST_RST = '{cnt: ccop_pkg::PWM_CNT_RST, period: ccop_pkg::PERIOD_RST,
      stage: ccop_pkg::STAGE_RST, duty: ccop_pkg::DUTY_RST, pin: 1'b0};

   ccop_pwm_state_type st_ff;
   ccop_pwm_state_type nxt_st;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   assign period_match = tick & ~standby & (st_ff.cnt == st_ff.period);

   always_comb begin
      nxt_st = st_ff;
      if (period_match) begin
         nxt_st.cnt = ccop_pkg::PWM_RELOAD;
         nxt_st.duty = st_ff.stage;
      end else if (tick) begin
         nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
      if (st_ff.duty == 16'h0000) begin
         nxt_st.pin = 1'b0;
      end else if (st_ff.duty >= st_ff.period) begin
         nxt_st.pin = 1'b1;
      end else if (period_match) begin
         nxt_st.pin = 1'b1;
      end else if (st_ff.cnt == st_ff.duty) begin
         nxt_st.pin = 1'b0;
      end
      if (wr_period) nxt_st.period = wdata;
      if (wr_stage) nxt_st.stage = wdata;
      if (wr_duty) nxt_st.duty = wdata;
      if (standby) nxt_st = ST_RST;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign period = st_ff.period;
   assign stage = st_ff.stage;
   assign duty = st_ff.duty;
   assign pwm_output_pin = st_ff.pin;

   a_pwm_reload: assert property (period_match && !wr_duty |=> st_ff.cnt == 16'h0001 && duty == $past(stage))
      else $error("period match did not reload counter and duty");
   a_pwm_zero: assert property (duty == 16'h0000 && !standby |=> !pwm_output_pin)
      else $error("zero duty did not hold pin low");
endmodule // ccop_pwm

// [src/ccop_timer.sv]
// Register block of the multi-channel timer: capcomp, one-shot, offset base, PWM.
// Assumes counters 1..5 and prescaled ticks come from same-clock logic;
// pins arrive asynchronously and are synchronised here.
module ccop_timer (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   input  wire logic                                standby,
   // Internal word bus
   input  wire ccop_pkg::ccop_bus_req_type          bus_req,
   output ccop_pkg::ccop_bus_rsp_type               bus_rsp,
   // Capcomp channel setup and counters
   input  wire ccop_pkg::ccop_io_type [17:0]        io_control_reg,
   input  wire logic [4:0][15:0]                    free_run_counter,
   input  wire logic [4:0]                          free_run_step,
   // Capture pins and offset-base edge select
   input  wire logic [17:0]                         cap_pin,
   input  wire logic                                ch0_capture_a,
   input  wire logic [1:0]                          ch1_io_control_a,
   // Prescaled ticks
   input  wire logic                                down_tick_af,
   input  wire logic                                down_tick_gh,
   input  wire logic [3:0]                          pwm_tick,
   // Pins and events out
   output logic [17:0]                              cc_pin_out,
   output logic [17:0]                              cc_pin_oe_n,
   output logic [1:0]                               pulse_sequencer_match,
   output logic [7:0]                               oneshot_pin,
   output logic [3:0]                               pwm_output_pin
);
   typedef struct packed {
      logic [17:0][15:0] cc;
      logic [17:0]       cc_pin;
      logic [17:0]       cc_flag;
      logic [17:0]       s1;
      logic [17:0]       s2;
      logic [17:0]       s3;
      logic [2:0]        tg;
      logic [15:0]       obase;
      logic [7:0]        start;
      logic [7:0]        link;
      logic [7:0]        dflag;
      logic [3:0]        pflag;
      logic [1:0]        cm2;
      logic [15:0]       rdata;
      logic              ack;
   } ccop_main_state_type;

   localparam ccop_main_state_type ST_RST = '{cc: {18{ccop_pkg::CC_RST}}, cc_pin: 18'h00000,
      cc_flag: 18'h00000, s1: 18'h00000, s2: 18'h00000, s3: 18'h00000, tg: 3'h0,
      obase: ccop_pkg::OBASE_RST, start: 8'h00, link: 8'h00, dflag: 8'h00, pflag: 4'h0,
      cm2: 2'h0, rdata: 16'h0000, ack: 1'b0};

   ccop_main_state_type st_ff;
   ccop_main_state_type nxt_st;

   logic        wr_ok;
   logic        rd_ok;
   logic [17:0] match;
   logic [17:0] cap_hit;
   logic        obase_hit;
   logic [17:0] cc_clr;
   logic [15:0] rd_val;
   logic [7:0][15:0] down_val;
   logic [7:0]  uflow;
   logic [3:0][15:0] period_val;
   logic [3:0][15:0] stage_val;
   logic [3:0][15:0] duty_val;
   logic [3:0]  pmatch;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   assign wr_ok = bus_req.req & bus_req.we & bus_req.word;
   assign rd_ok = bus_req.req & ~bus_req.we & bus_req.word;

   // Compare and capture detection per capcomp register
   always_comb begin
      for (int i = 0; i < 18; i++) begin
         match[i] = ~io_control_reg[i].capture & free_run_step[ccop_pkg::cc_chan(i)]
                    & (free_run_counter[ccop_pkg::cc_chan(i)] == st_ff.cc[i]);
         cap_hit[i] = io_control_reg[i].capture
                      & ccop_pkg::edge_hit(io_control_reg[i].edge_sel, st_ff.s3[i], st_ff.s2[i]);
      end
   end

   assign obase_hit = ccop_pkg::edge_hit(ch1_io_control_a, st_ff.tg[2], st_ff.tg[1]);

   // Flag clears by writing ones
   always_comb begin
      cc_clr = 18'h00000;
      if (wr_ok && bus_req.addr == ccop_pkg::CCFLAG_LO) cc_clr[15:0] = bus_req.wdata;
      if (wr_ok && bus_req.addr == ccop_pkg::CCFLAG_HI) cc_clr[17:16] = bus_req.wdata[1:0];
   end

   // Read mux; unmapped words read as zero
   always_comb begin
      rd_val = 16'h0000;
      for (int i = 0; i < 18; i++) begin
         if (bus_req.addr == 7'(ccop_pkg::CC_BASE + i)) rd_val = st_ff.cc[i];
      end
      for (int k = 0; k < 8; k++) begin
         if (bus_req.addr == 7'(ccop_pkg::DOWN_BASE + k)) rd_val = down_val[k];
      end
      for (int p = 0; p < 4; p++) begin
         if (bus_req.addr == 7'(ccop_pkg::PERIOD_BASE + p)) rd_val = period_val[p];
         if (bus_req.addr == 7'(ccop_pkg::STAGE_BASE + p)) rd_val = stage_val[p];
         if (bus_req.addr == 7'(ccop_pkg::DUTY_BASE + p)) rd_val = duty_val[p];
      end
      unique case (bus_req.addr)
         ccop_pkg::OBASE_IDX: rd_val = st_ff.obase;
         ccop_pkg::START_IDX: rd_val = {8'h00, st_ff.start};
         ccop_pkg::LINK_IDX:  rd_val = {8'h00, st_ff.link};
         ccop_pkg::CCFLAG_LO: rd_val = st_ff.cc_flag[15:0];
         ccop_pkg::CCFLAG_HI: rd_val = {14'h0000, st_ff.cc_flag[17:16]};
         ccop_pkg::DFLAG_IDX: rd_val = {8'h00, st_ff.dflag};
         ccop_pkg::PFLAG_IDX: rd_val = {12'h000, st_ff.pflag};
         default: ;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      for (int i = 0; i < 18; i++) begin
         if (wr_ok && bus_req.addr == 7'(ccop_pkg::CC_BASE + i)) nxt_st.cc[i] = bus_req.wdata;
         if (cap_hit[i]) nxt_st.cc[i] = free_run_counter[ccop_pkg::cc_chan(i)];
         if (match[i]) begin
            unique case (io_control_reg[i].out_act)
               ccop_pkg::ACT_NONE:   nxt_st.cc_pin[i] = st_ff.cc_pin[i];
               ccop_pkg::ACT_LOW:    nxt_st.cc_pin[i] = 1'b0;
               ccop_pkg::ACT_HIGH:   nxt_st.cc_pin[i] = 1'b1;
               ccop_pkg::ACT_TOGGLE: nxt_st.cc_pin[i] = ~st_ff.cc_pin[i];
            endcase
         end
      end
      nxt_st.cc_flag = (st_ff.cc_flag & ~cc_clr) | match | cap_hit;
      nxt_st.cm2 = match[7:6];
      // no write path to offset base
      if (obase_hit) nxt_st.obase = free_run_counter[0];
      if (wr_ok && bus_req.addr == ccop_pkg::LINK_IDX) nxt_st.link = bus_req.wdata[7:0];
      if (wr_ok && bus_req.addr == ccop_pkg::START_IDX) nxt_st.start = bus_req.wdata[7:0];
      nxt_st.start = nxt_st.start | (st_ff.link & match[7:0]);
      nxt_st.start = nxt_st.start & ~uflow;
      nxt_st.dflag = st_ff.dflag | uflow;
      if (wr_ok && bus_req.addr == ccop_pkg::DFLAG_IDX) begin
         nxt_st.dflag = (st_ff.dflag & ~bus_req.wdata[7:0]) | uflow;
      end
      nxt_st.pflag = st_ff.pflag | pmatch;
      if (wr_ok && bus_req.addr == ccop_pkg::PFLAG_IDX) begin
         nxt_st.pflag = (st_ff.pflag & ~bus_req.wdata[3:0]) | pmatch;
      end
      if (standby) begin
         nxt_st = ST_RST;
      end
      // Pin synchronisers: first stage feeds only the second
      // Kept through standby so a pin held high gives no false edge
      nxt_st.s1 = cap_pin;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.tg = {st_ff.tg[1:0], ch0_capture_a};
      // Bus answers even in standby; odd sizes read zero
      nxt_st.ack = bus_req.req;
      nxt_st.rdata = rd_ok ? rd_val : 16'h0000;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // eight down-counters, ticks split A-F and G-H
   for (genvar k = 0; k < 8; k++) begin : g_oneshot
      ccop_oneshot u_oneshot (
         .clk       (clk),
         .rst_n     (rst_n),
         .standby   (standby),
         .wr_en     (wr_ok && bus_req.addr == 7'(ccop_pkg::DOWN_BASE + k)),
         .wdata     (bus_req.wdata),
         .tick      ((k < 6) ? down_tick_af : down_tick_gh),
         .run       (st_ff.start[k]),
         .count     (down_val[k]),
         .underflow (uflow[k])
      );
   end

   for (genvar p = 0; p < 4; p++) begin : g_pwm
      ccop_pwm u_pwm (
         .clk            (clk),
         .rst_n          (rst_n),
         .standby        (standby),
         .tick           (pwm_tick[p]),
         .wr_period      (wr_ok && bus_req.addr == 7'(ccop_pkg::PERIOD_BASE + p)),
         .wr_stage       (wr_ok && bus_req.addr == 7'(ccop_pkg::STAGE_BASE + p)),
         .wr_duty        (wr_ok && bus_req.addr == 7'(ccop_pkg::DUTY_BASE + p)),
         .wdata          (bus_req.wdata),
         .period         (period_val[p]),
         .stage          (stage_val[p]),
         .duty           (duty_val[p]),
         .pwm_output_pin (pwm_output_pin[p]),
         .period_match   (pmatch[p])
      );
   end

   assign bus_rsp.ack = st_ff.ack;
   assign bus_rsp.rdata = st_ff.rdata;
   assign cc_pin_out = st_ff.cc_pin;
   assign pulse_sequencer_match = st_ff.cm2;
   assign oneshot_pin = st_ff.start;
   always_comb begin
      for (int i = 0; i < 18; i++) cc_pin_oe_n[i] = io_control_reg[i].capture;
   end

   a_cc_standby: assert property (standby |=> st_ff.cc[0] == 16'hFFFF && st_ff.cc[17] == 16'hFFFF)
      else $error("capcomp not all ones after standby");
   a_cap_load: assert property (cap_hit[8] && !standby |=> st_ff.cc[8] == $past(free_run_counter[2]) && st_ff.cc_flag[8])
      else $error("capture did not load counter and flag");
   a_cmp_flag: assert property (match[6] && !standby |=> st_ff.cc_flag[6])
      else $error("compare match did not set flag");
   a_pin_high: assert property (match[6] && io_control_reg[6].out_act == ccop_pkg::ACT_HIGH && !standby |=> cc_pin_out[6])
      else $error("compare pin action not applied");
   a_seq_fwd: assert property (match[6] && !standby |=> pulse_sequencer_match[0])
      else $error("channel 2 match not forwarded");
   a_uflow_stop: assert property (uflow[0] && !standby |=> !oneshot_pin[0] && st_ff.dflag[0])
      else $error("underflow did not stop and flag");
   a_link_start: assert property (st_ff.link[6] && match[6] && !uflow[6] && !standby |=> oneshot_pin[6])
      else $error("linked match did not start counter");
   a_obase_load: assert property (obase_hit && !standby |=> st_ff.obase == $past(free_run_counter[0]))
      else $error("offset base did not capture");
   a_odd_size: assert property (bus_req.req && !bus_req.word |=> bus_rsp.ack && bus_rsp.rdata == 16'h0000)
      else $error("non-word access returned data");
endmodule // ccop_timer

// [bench/ccop_cpu.sv]
// Processor-side model: word and odd-size accesses on the timer's internal bus.
// Assumes the block acks exactly one cycle after each one-cycle request.
module ccop_cpu (
   // Bus
   input  wire logic                       clk,
   output ccop_pkg::ccop_bus_req_type      bus_req,
   input  wire ccop_pkg::ccop_bus_rsp_type bus_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial bus_req = '0;
   task automatic xfer(input logic we, input logic wd, input logic [6:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge clk);
      #1;
      bus_req = '{req: 1'b1, we: we, word: wd, addr: a, wdata: d};
      @(posedge clk);
      #1;
      bus_req.req = 1'b0;
      // Missing ack reads as unknown so the caller's compare fails
      q = (bus_rsp.ack === 1'b1) ? bus_rsp.rdata : 16'hXXXX;
   endtask
endmodule // ccop_cpu

// [bench/testbench.sv]
// Self-checking bench of the timer register block.
// Assumes the processor model drives the bus; pins, counters and ticks come from here.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                          clk = 1'b0;
   logic                          rst_n = 1'b0;
   logic                          standby = 1'b0;
   ccop_pkg::ccop_bus_req_type    bus_req;
   ccop_pkg::ccop_bus_rsp_type    bus_rsp;
   ccop_pkg::ccop_io_type [17:0]  io_ctl = '0;
   logic [4:0][15:0]              frc = '0;
   logic [4:0]                    frs = '0;
   logic [17:0]                   cap = '0;
   logic                          cap0 = 1'b0;
   logic [1:0]                    c1io = 2'h0;
   logic                          tk_af = 1'b0;
   logic                          tk_gh = 1'b0;
   logic [3:0]                    tk_pwm = 4'h0;
   logic [17:0]                   cc_out;
   logic [17:0]                   cc_oe_n;
   logic [1:0]                    seq;
   logic [7:0]                    os_pin;
   logic [3:0]                    pwm_pin;
   logic [15:0]                   q;
   logic                          hit;
   int                            n_mismatch = 0;
   int                            n_tests = 0;

   always #10 clk = ~clk;

   ccop_cpu cpu (.clk(clk), .bus_req(bus_req), .bus_rsp(bus_rsp));
   ccop_timer DUT (
      .clk(clk), .rst_n(rst_n), .standby(standby), .bus_req(bus_req), .bus_rsp(bus_rsp),
      .io_control_reg(io_ctl), .free_run_counter(frc), .free_run_step(frs), .cap_pin(cap),
      .ch0_capture_a(cap0), .ch1_io_control_a(c1io), .down_tick_af(tk_af), .down_tick_gh(tk_gh),
      .pwm_tick(tk_pwm), .cc_pin_out(cc_out), .cc_pin_oe_n(cc_oe_n), .pulse_sequencer_match(seq),
      .oneshot_pin(os_pin), .pwm_output_pin(pwm_pin)
   );

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rc(input logic [6:0] a, input logic [15:0] e);
      cpu.xfer(1'b0, 1'b1, a, 16'h0000, q);
      chk($sformatf("word %h", a), e, q);
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      cpu.xfer(1'b1, 1'b1, a, d, q);
   endtask
   // Kind 1 ticks PWM channel 6, kind 2 one-shots G-H, else one-shots A-F
   task automatic tick(input int kind);
      if (kind == 1) tk_pwm = 4'h1;
      else if (kind == 2) tk_gh = 1'b1;
      else tk_af = 1'b1;
      step(1);
      tk_pwm = 4'h0;
      tk_af = 1'b0;
      tk_gh = 1'b0;
      step(1);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Tests need well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      step(5);
      rst_n = 1'b1;
      for (int a = 0; a < 39; a++) rc(a[6:0], (a >= 18 && a < 27) ? 16'h0000 : 16'hFFFF);
      wr(7'h03, 16'hA5A5);
      rc(7'h03, 16'hA5A5);
      cpu.xfer(1'b1, 1'b0, 7'h03, 16'h0000, q);
      rc(7'h03, 16'hA5A5);
      rc(7'h7F, 16'h0000);
      // Capture on channel 3 A
      io_ctl[8] = '{capture: 1'b1, edge_sel: ccop_pkg::EDGE_RISE, out_act: ccop_pkg::ACT_NONE};
      frc[2] = 16'hBEEF;
      cap[8] = 1'b1;
      step(6);
      rc(7'h08, 16'hBEEF);
      rc(7'h29, 16'h0100);
      // Falling edge selected: offset base holds the counter seen at the fall, writes ignored
      c1io = ccop_pkg::EDGE_FALL;
      frc[0] = 16'h0F0F;
      cap0 = 1'b1;
      step(6);
      frc[0] = 16'h1234;
      cap0 = 1'b0;
      step(6);
      rc(7'h1A, 16'h1234);
      wr(7'h1A, 16'h0000);
      rc(7'h1A, 16'h1234);
      // Compare on channel 2 A, linked to one-shot G
      io_ctl[6] = '{capture: 1'b0, edge_sel: ccop_pkg::EDGE_RISE, out_act: ccop_pkg::ACT_HIGH};
      wr(7'h06, 16'h0042);
      wr(7'h28, 16'h0040);
      frc[1] = 16'h0042;
      frs[1] = 1'b1;
      hit = 1'b0;
      for (int i = 0; i < 4; i++) begin
         step(1);
         frs[1] = 1'b0;
         hit |= seq[0];
      end
      chk("sequencer", 16'h0001, {15'h0, hit});
      chk("compare pin", 16'h0001, {15'h0, cc_out[6]});
      chk("compare drive", 16'h0000, {15'h0, cc_oe_n[6]});
      chk("linked pin", 16'h0001, {15'h0, os_pin[6]});
      rc(7'h29, 16'h0140);
      rc(7'h27, 16'h0040);
      // One-shot G started at zero: first G-H tick underflows it
      tick(2);
      chk("linked end", 16'h0000, {15'h0, os_pin[6]});
      // Software one-shot A: count first, then start
      wr(7'h12, 16'h0003);
      wr(7'h27, 16'h0001);
      chk("oneshot start", 16'h0001, {15'h0, os_pin[0]});
      repeat (3) tick(1'b0);
      rc(7'h12, 16'h0000);
      rc(7'h27, 16'h0001);
      tick(1'b0);
      rc(7'h27, 16'h0000);
      rc(7'h2B, 16'h0041);
      chk("oneshot end", 16'h0000, {15'h0, os_pin[0]});
      // PWM channel 6
      wr(7'h1B, 16'h0004);
      wr(7'h1F, 16'h0002);
      chk("pwm full", 16'h0001, {15'h0, pwm_pin[0]});
      repeat (4) tick(1'b1);
      rc(7'h23, 16'h0002);
      rc(7'h2C, 16'h0001);
      chk("pwm rise", 16'h0001, {15'h0, pwm_pin[0]});
      repeat (2) tick(1'b1);
      chk("pwm fall", 16'h0000, {15'h0, pwm_pin[0]});
      repeat (2) tick(1'b1);
      chk("pwm period", 16'h0001, {15'h0, pwm_pin[0]});
      wr(7'h23, 16'h0000);
      step(1);
      chk("pwm zero", 16'h0000, {15'h0, pwm_pin[0]});
      standby = 1'b1;
      step(1);
      standby = 1'b0;
      rc(7'h03, 16'hFFFF);
      rc(7'h1A, 16'h0000);
      rc(7'h1B, 16'hFFFF);
      close_out();
   end
endmodule // testbench
